// ===== verilog/dadc_pkg.sv
// constants, register map and carrier types of the dual converter output
// control block; assumes a 100 MHz system clock and a 32-bit APB slave
package dadc_pkg;

   localparam int unsigned DADC_WORD_W      = 11;
   localparam int unsigned DADC_LATENCY     = 6;
   localparam logic [2:0]  DADC_FILL_FULL   = 3'h6;
   localparam logic [2:0]  DADC_FILL_RESET  = 3'h0;
   localparam logic [10:0] DADC_MSB_MASK    = 11'h400;
   localparam logic [10:0] DADC_WORD_RESET  = 11'h000;

   // system clock and rated conversion clock
   localparam int unsigned DADC_CLK_PERIOD_NS = 10;
   localparam int unsigned DADC_CLK_MHZ       = 1000 / DADC_CLK_PERIOD_NS;
   localparam int unsigned DADC_RATED_MHZ     = 66;
   // tick every (div + 1) cycles; reset value keeps the rate at or above rated
   localparam logic [7:0]  DADC_DIV_RESET     =
      8'(DADC_CLK_MHZ / DADC_RATED_MHZ - 1);
   localparam logic [7:0]  DADC_DIV_CNT_RESET = 8'h00;

   // register byte offsets
   localparam logic [7:0] DADC_OFS_CTRL   = 8'h00;
   localparam logic [7:0] DADC_OFS_DIV    = 8'h04;
   localparam logic [7:0] DADC_OFS_STATUS = 8'h08;
   localparam logic [7:0] DADC_OFS_RES_A  = 8'h0C;
   localparam logic [7:0] DADC_OFS_RES_B  = 8'h10;
   localparam logic [7:0] DADC_OFS_COUNT  = 8'h14;

   // control register fields, bit 4 downward
   typedef struct packed {
      logic ref_source_select;
      logic format_select;
      logic powerdown;
      logic out_en_n_ch_b;
      logic out_en_n_ch_a;
   } dadc_ctrl_type;

   localparam int unsigned DADC_CTRL_W = 5;
   localparam dadc_ctrl_type DADC_CTRL_RESET = '{
      ref_source_select : 1'b0,
      format_select     : 1'b0,
      powerdown         : 1'b0,
      out_en_n_ch_b     : 1'b1,
      out_en_n_ch_a     : 1'b1
   };

   // status register bits
   localparam int unsigned DADC_ST_PD_BIT     = 0;
   localparam int unsigned DADC_ST_PRIMED_BIT = 1;
   localparam int unsigned DADC_ST_REF_BIT    = 2;

   localparam logic [31:0] DADC_COUNT_RESET = 32'h0000_0000;
   localparam logic [31:0] DADC_DATA_RESET  = 32'h0000_0000;

endpackage : dadc_pkg

// ===== verilog/dadc_delay_line.sv
// fixed-depth word delay line that advances on an enable pulse
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
module dadc_delay_line #(
   parameter int unsigned WIDTH = 11,
   parameter int unsigned DEPTH = 6
) (
   input  wire logic             clock_in,
   input  wire logic             rstn_in,
   input  wire logic             advance_in,
   input  wire logic [WIDTH-1:0] word_in,
   output logic      [WIDTH-1:0] word_out
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] stage;
   } dadc_dl_state_type;

   dadc_dl_state_type            state_r;
   dadc_dl_state_type            state_nxt;
   logic [DEPTH-1:0][WIDTH-1:0]  shifted;

   // each stage takes its predecessor, stage 0 the new word
   for (genvar i = 0; i < DEPTH; i++)
   begin : g_stage
      if (i == 0)
      begin : g_first
         assign shifted[i] = word_in;
      end
      else
      begin : g_next
         assign shifted[i] = state_r.stage[i-1];
      end
   end

   always_comb
   begin
      state_nxt = state_r;
      if (advance_in)
      begin
         state_nxt.stage = shifted;
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         state_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign word_out = state_r.stage[DEPTH-1];

endmodule : dadc_delay_line

// ===== verilog/dadc_output_ctrl.sv
// top of the dual converter output control: conversion tick, pipelines,
// output format and enables, APB register file
// assumes quantiser codes arrive synchronous to clock_in, offset binary
//
// Contract
// - sample both channels on every conversion tick
// - result appears six ticks after sampling
// - two channels, separate 11-bit result buses
// - bus driven when enable low, released high
// - powerdown high stops conversion, low runs
// - format low offset binary, high two's complement
// - reference select low internal, high external
// - at least 66 megasamples per second each; only div 0 meets it (100), div 1 and up give 50 or less
// - bit 0 least, bit 10 most significant
`timescale 1ns/1ps
module dadc_output_ctrl (
   input  wire logic        clock_in,
   input  wire logic        rstn_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic [10:0] sample_ch_a_in,
   input  wire logic [10:0] sample_ch_b_in,
   output logic      [10:0] result_bus_ch_a_out,
   output logic             result_bus_ch_a_oe_out,
   output logic      [10:0] result_bus_ch_b_out,
   output logic             result_bus_ch_b_oe_out,
   output logic             word_strobe_out,
   output logic             powerdown_out,
   output logic             ref_source_select_out
);

   typedef struct packed {
      dadc_pkg::dadc_ctrl_type ctrl;
      logic [7:0]              div;
      logic [7:0]              div_cnt;
      logic                    tick;
      logic [2:0]              fill;
      logic [10:0]             res_a;
      logic [10:0]             res_b;
      logic                    oe_a;
      logic                    oe_b;
      logic                    strobe;
      logic [31:0]             count;
      logic                    pready;
      logic                    pslverr;
      logic [31:0]             prdata;
      logic                    pd;
      logic                    ref_ext;
   } dadc_state_type;

   localparam dadc_state_type DADC_STATE_RESET = '{
      ctrl    : dadc_pkg::DADC_CTRL_RESET,
      div     : dadc_pkg::DADC_DIV_RESET,
      div_cnt : dadc_pkg::DADC_DIV_CNT_RESET,
      tick    : 1'b0,
      fill    : dadc_pkg::DADC_FILL_RESET,
      res_a   : dadc_pkg::DADC_WORD_RESET,
      res_b   : dadc_pkg::DADC_WORD_RESET,
      oe_a    : ~dadc_pkg::DADC_CTRL_RESET.out_en_n_ch_a,
      oe_b    : ~dadc_pkg::DADC_CTRL_RESET.out_en_n_ch_b,
      strobe  : 1'b0,
      count   : dadc_pkg::DADC_COUNT_RESET,
      pready  : 1'b0,
      pslverr : 1'b0,
      prdata  : dadc_pkg::DADC_DATA_RESET,
      pd      : dadc_pkg::DADC_CTRL_RESET.powerdown,
      ref_ext : dadc_pkg::DADC_CTRL_RESET.ref_source_select
   };

   dadc_state_type state_r;
   dadc_state_type state_nxt;
   logic [10:0]    delayed_a;
   logic [10:0]    delayed_b;
   logic           apb_done;
   logic           apb_wait;
   logic           addr_hit;
   logic [31:0]    rd_word;
   logic [10:0]    fmt_mask;

   // one pipeline per channel, each six ticks deep
   dadc_delay_line #(
      .WIDTH (dadc_pkg::DADC_WORD_W),
      .DEPTH (dadc_pkg::DADC_LATENCY)
   ) u_pipe_a (
      .clock_in   (clock_in),
      .rstn_in    (rstn_in),
      .advance_in (state_r.tick),
      .word_in    (sample_ch_a_in),
      .word_out   (delayed_a)
   );

   dadc_delay_line #(
      .WIDTH (dadc_pkg::DADC_WORD_W),
      .DEPTH (dadc_pkg::DADC_LATENCY)
   ) u_pipe_b (
      .clock_in   (clock_in),
      .rstn_in    (rstn_in),
      .advance_in (state_r.tick),
      .word_in    (sample_ch_b_in),
      .word_out   (delayed_b)
   );

   // read mux and address decode
   always_comb
   begin
      addr_hit = 1'b1;
      rd_word  = dadc_pkg::DADC_DATA_RESET;
      if (paddr_in == dadc_pkg::DADC_OFS_CTRL)
      begin
         rd_word[dadc_pkg::DADC_CTRL_W-1:0] = state_r.ctrl;
      end
      else if (paddr_in == dadc_pkg::DADC_OFS_DIV)
      begin
         rd_word[7:0] = state_r.div;
      end
      else if (paddr_in == dadc_pkg::DADC_OFS_STATUS)
      begin
         rd_word[dadc_pkg::DADC_ST_PD_BIT]     = state_r.ctrl.powerdown;
         rd_word[dadc_pkg::DADC_ST_PRIMED_BIT] =
            (state_r.fill == dadc_pkg::DADC_FILL_FULL);
         rd_word[dadc_pkg::DADC_ST_REF_BIT]    =
            state_r.ctrl.ref_source_select;
      end
      else if (paddr_in == dadc_pkg::DADC_OFS_RES_A)
      begin
         rd_word[10:0] = state_r.res_a;
      end
      else if (paddr_in == dadc_pkg::DADC_OFS_RES_B)
      begin
         rd_word[10:0] = state_r.res_b;
      end
      else if (paddr_in == dadc_pkg::DADC_OFS_COUNT)
      begin
         rd_word = state_r.count;
      end
      else
      begin
         addr_hit = 1'b0;
      end
   end

   assign apb_done = psel_in && penable_in && state_r.pready;
   assign apb_wait = psel_in && penable_in && !state_r.pready;
   assign fmt_mask = state_r.ctrl.format_select ?
                     dadc_pkg::DADC_MSB_MASK : dadc_pkg::DADC_WORD_RESET;

   always_comb
   begin
      state_nxt = state_r;

      // APB: one wait state, then completion
      state_nxt.pready = apb_wait;
      if (apb_wait)
      begin
         state_nxt.pslverr = !addr_hit;
         state_nxt.prdata  = pwrite_in ? dadc_pkg::DADC_DATA_RESET
                                       : rd_word;
      end
      else
      begin
         state_nxt.pslverr = 1'b0;
      end
      if (apb_done && pwrite_in && addr_hit)
      begin
         if (paddr_in == dadc_pkg::DADC_OFS_CTRL)
         begin
            state_nxt.ctrl = pwdata_in[dadc_pkg::DADC_CTRL_W-1:0];
         end
         else if (paddr_in == dadc_pkg::DADC_OFS_DIV)
         begin
            state_nxt.div = pwdata_in[7:0];
         end
      end

      // output enables, powerdown and reference follow control
      state_nxt.oe_a    = !state_nxt.ctrl.out_en_n_ch_a;
      state_nxt.oe_b    = !state_nxt.ctrl.out_en_n_ch_b;
      state_nxt.pd      = state_nxt.ctrl.powerdown;
      state_nxt.ref_ext = state_nxt.ctrl.ref_source_select;

      // conversion tick divider, stopped in powerdown
      state_nxt.tick = 1'b0;
      if (state_r.ctrl.powerdown)
      begin
         state_nxt.div_cnt = dadc_pkg::DADC_DIV_CNT_RESET;
      end
      else if (state_r.div_cnt >= state_r.div)
      begin
         state_nxt.div_cnt = dadc_pkg::DADC_DIV_CNT_RESET;
         state_nxt.tick    = 1'b1;
      end
      else
      begin
         state_nxt.div_cnt = 8'(state_r.div_cnt + 8'h01);
      end

      // pipeline contents go stale across powerdown
      state_nxt.strobe = 1'b0;
      if (state_r.ctrl.powerdown)
      begin
         state_nxt.fill = dadc_pkg::DADC_FILL_RESET;
      end
      else if (state_r.tick)
      begin
         // sixth tick after sampling loads the output word
         state_nxt.res_a  = delayed_a ^ fmt_mask;
         state_nxt.res_b  = delayed_b ^ fmt_mask;
         state_nxt.count  = 32'(state_r.count + 32'h0000_0001);
         state_nxt.strobe = (state_r.fill == dadc_pkg::DADC_FILL_FULL);
         if (state_r.fill != dadc_pkg::DADC_FILL_FULL)
         begin
            state_nxt.fill = 3'(state_r.fill + 3'h1);
         end
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         state_r <= DADC_STATE_RESET;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign prdata_out             = state_r.prdata;
   assign pready_out             = state_r.pready;
   assign pslverr_out            = state_r.pslverr;
   assign result_bus_ch_a_out    = state_r.res_a;
   assign result_bus_ch_b_out    = state_r.res_b;
   assign result_bus_ch_a_oe_out = state_r.oe_a;
   assign result_bus_ch_b_oe_out = state_r.oe_b;
   assign word_strobe_out        = state_r.strobe;
   assign powerdown_out          = state_r.pd;
   assign ref_source_select_out  = state_r.ref_ext;

   // checks
   // seven running ticks: one to take the sample, six to reach the bus
   sequence s_run7;
      (state_r.tick && !state_r.ctrl.powerdown) [*7];
   endsequence

   sequence s_setup;
      psel_in && !penable_in;
   endsequence

   sequence s_access;
      psel_in && penable_in && !state_r.pready;
   endsequence

   sequence s_ctrl_wr;
      apb_done && pwrite_in && (paddr_in == dadc_pkg::DADC_OFS_CTRL);
   endsequence

   AST_LATENCY_A: assert property (
      @(posedge clock_in) disable iff (!rstn_in)
      s_run7 |=> (result_bus_ch_a_out == ($past(sample_ch_a_in, 7) ^
         ($past(state_r.ctrl.format_select) ? 11'h400 : 11'h000))))
      else $error("channel a word not six ticks after its sample");

   AST_LATENCY_B: assert property (
      @(posedge clock_in) disable iff (!rstn_in)
      s_run7 |=> (result_bus_ch_b_out == ($past(sample_ch_b_in, 7) ^
         ($past(state_r.ctrl.format_select) ? 11'h400 : 11'h000))))
      else $error("channel b word not six ticks after its sample");

   AST_OE_A: assert property (
      @(posedge clock_in) disable iff (!rstn_in)
      s_ctrl_wr |=> (result_bus_ch_a_oe_out == !$past(pwdata_in[0])))
      else $error("channel a enable does not follow control write");

   AST_OE_B: assert property (
      @(posedge clock_in) disable iff (!rstn_in)
      s_ctrl_wr |=> (result_bus_ch_b_oe_out == !$past(pwdata_in[1])))
      else $error("channel b enable does not follow control write");

   AST_PD_HOLD: assert property (
      @(posedge clock_in) disable iff (!rstn_in)
      powerdown_out [*2] |=> !word_strobe_out && $stable(result_bus_ch_a_out)
         && $stable(result_bus_ch_b_out))
      else $error("conversion continued in powerdown");

   AST_REF: assert property (
      @(posedge clock_in) disable iff (!rstn_in)
      s_ctrl_wr |=> (ref_source_select_out == $past(pwdata_in[4])))
      else $error("reference select does not follow control write");

   AST_RATE: assert property (
      @(posedge clock_in) disable iff (!rstn_in)
      (state_r.div == 8'h00 && !state_r.ctrl.powerdown) [*2]
         |-> state_r.tick)
      else $error("tick missing at full rate");

   AST_DIV2: assert property (
      @(posedge clock_in) disable iff (!rstn_in)
      (state_r.tick && state_r.div == 8'h02 && !state_r.ctrl.powerdown)
         ##1 (state_r.div == 8'h02 && !state_r.ctrl.powerdown) [*3]
         |-> state_r.tick && !$past(state_r.tick, 1)
             && !$past(state_r.tick, 2))
      else $error("divided tick spacing wrong");

   AST_STREAM: assert property (
      @(posedge clock_in) disable iff (!rstn_in)
      word_strobe_out && !state_r.ctrl.powerdown && state_r.tick
         |=> word_strobe_out)
      else $error("primed stream dropped a word");

   AST_APB_WAIT: assert property (
      @(posedge clock_in) disable iff (!rstn_in)
      s_setup ##1 s_access |=> pready_out && (pslverr_out == !$past(addr_hit)))
      else $error("apb answer not one wait state after access");

endmodule : dadc_output_ctrl

// ===== sim/dadc_far_end.sv
// far-end model: feeds quantiser codes and captures the result buses
// assumes the bench judges results against cnt_out, one code per cycle
`timescale 1ns/1ps
module dadc_far_end (
   input  wire logic        clock_in,
   input  wire logic        rstn_in,
   input  wire logic [10:0] res_a_in,
   input  wire logic        oe_a_in,
   input  wire logic [10:0] res_b_in,
   input  wire logic        oe_b_in,
   input  wire logic        ref_sel_in,
   output logic      [10:0] sample_a_out,
   output logic      [10:0] sample_b_out,
   output logic      [10:0] cnt_out,
   output wire       [10:0] bus_a_out,
   output wire       [10:0] bus_b_out,
   output logic             ext_ref_out
);
   // a new code every cycle; channel b carries the inverse of a
   always_ff @(posedge clock_in or negedge rstn_in)
      if (!rstn_in)
         cnt_out <= 11'h000;
      else
         cnt_out <= cnt_out + 11'h001;
   assign sample_a_out = cnt_out;
   assign sample_b_out = ~cnt_out;
   // a released bus floats on the board
   assign bus_a_out = oe_a_in ? res_a_in : 11'hZZZ;
   assign bus_b_out = oe_b_in ? res_b_in : 11'hZZZ;
   // external reference supplied whenever it is selected
   assign ext_ref_out = ref_sel_in;
endmodule : dadc_far_end

// ===== sim/testbench.sv
// self-checking bench of the dual converter output control block
// assumes an APB slave with one wait state and the far-end model
`timescale 1ns/1ps
module testbench;
   logic        clock_in, rstn_in, psel_in, penable_in, pwrite_in;
   logic [7:0]  paddr_in;
   logic [31:0] pwdata_in, prdata_out, rd, rd2;
   logic        pready_out, pslverr_out, err;
   logic [10:0] sample_a, sample_b, cnt, res_a, res_b, e, eb, m;
   wire  [10:0] bus_a, bus_b;
   logic        oe_a, oe_b, strobe, pd_out, ref_out, ext_ref;
   int          n_mismatch = 0;
   int          checked = 0;
   int          cycles = 0;
   int          n;

   dadc_output_ctrl DUT (.clock_in(clock_in), .rstn_in(rstn_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
      .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out),
      .sample_ch_a_in(sample_a), .sample_ch_b_in(sample_b),
      .result_bus_ch_a_out(res_a), .result_bus_ch_a_oe_out(oe_a),
      .result_bus_ch_b_out(res_b), .result_bus_ch_b_oe_out(oe_b),
      .word_strobe_out(strobe), .powerdown_out(pd_out),
      .ref_source_select_out(ref_out));

   dadc_far_end far (.clock_in(clock_in), .rstn_in(rstn_in),
      .res_a_in(res_a), .oe_a_in(oe_a), .res_b_in(res_b), .oe_b_in(oe_b),
      .ref_sel_in(ref_out), .sample_a_out(sample_a),
      .sample_b_out(sample_b), .cnt_out(cnt), .bus_a_out(bus_a),
      .bus_b_out(bus_b), .ext_ref_out(ext_ref));

   initial
   begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   always @(posedge clock_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         n_mismatch++;
         results();
      end
   end

   task automatic results();
      $display("mismatches=%0d comparisons=%0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // one transfer; entered right after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      psel_in    <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in  <= wr;
      paddr_in   <= a;
      pwdata_in  <= d;
      @(posedge clock_in);
      penable_in <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clock_in);
         k++;
      end
      while (pready_out !== 1'b1 && k < 50);
      rd  = prdata_out;
      err = pslverr_out;
      if (k == 50)
         n_mismatch++;
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clock_in);
   endtask : apb

   task automatic t_reset();
      chk({oe_a, oe_b, strobe, pd_out, ref_out}, 0);
      chk(bus_a, 11'hZZZ);
      apb(1'b0, dadc_pkg::DADC_OFS_CTRL, 0);
      chk(rd, 32'h3);
      apb(1'b0, dadc_pkg::DADC_OFS_DIV, 0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h18, 0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      apb(1'b1, 8'h1C, 32'hF);
      chk(err, 1'b1);
      apb(1'b1, dadc_pkg::DADC_OFS_COUNT, 32'h0);
      chk(err, 1'b0);
   endtask : t_reset

   task automatic t_stream(input logic fmt);
      apb(1'b1, dadc_pkg::DADC_OFS_CTRL, {28'h0, fmt, 3'h0});
      m = fmt ? 11'h400 : 11'h000;
      n = 0;
      repeat (8) @(posedge clock_in);
      repeat (20)
      begin
         @(negedge clock_in);
         // sample taken at the end of its cycle, then six edges to the bus
         e  = cnt - 11'(dadc_pkg::DADC_LATENCY + 1);
         eb = ~e ^ m;
         e  = e ^ m;
         n  = n + int'(strobe);
         chk(bus_a, e);
         chk(bus_b, eb);
      end
      chk(n, 20);
      @(posedge clock_in);
   endtask : t_stream

   task automatic t_oe();
      apb(1'b1, dadc_pkg::DADC_OFS_CTRL, 32'h1);
      chk({oe_a, oe_b, bus_a}, {2'b01, 11'hZZZ});
      apb(1'b1, dadc_pkg::DADC_OFS_CTRL, 32'h2);
      chk({oe_a, oe_b, bus_b}, {2'b10, 11'hZZZ});
   endtask : t_oe

   task automatic t_pd();
      apb(1'b1, dadc_pkg::DADC_OFS_CTRL, 32'h4);
      chk(pd_out, 1'b1);
      apb(1'b0, dadc_pkg::DADC_OFS_STATUS, 0);
      chk(rd, 32'h1);
      apb(1'b0, dadc_pkg::DADC_OFS_COUNT, 0);
      rd2 = rd;
      e   = res_a;
      eb  = res_b;
      repeat (10)
      begin
         @(negedge clock_in);
         chk({strobe, res_a}, {1'b0, e});
      end
      @(posedge clock_in);
      apb(1'b0, dadc_pkg::DADC_OFS_COUNT, 0);
      chk(rd, rd2);
      apb(1'b0, dadc_pkg::DADC_OFS_RES_A, 0);
      chk(rd, {21'h0, e});
      apb(1'b0, dadc_pkg::DADC_OFS_RES_B, 0);
      chk(rd, {21'h0, eb});
      apb(1'b1, dadc_pkg::DADC_OFS_CTRL, 32'h0);
      n = 0;
      while (strobe !== 1'b1 && n < 20)
      begin
         @(negedge clock_in);
         n++;
      end
      chk(n >= 6 && n <= 8, 1'b1);
      @(posedge clock_in);
   endtask : t_pd

   task automatic t_ref();
      apb(1'b1, dadc_pkg::DADC_OFS_CTRL, 32'h10);
      chk({ref_out, ext_ref}, 2'b11);
      apb(1'b0, dadc_pkg::DADC_OFS_STATUS, 0);
      chk(rd, 32'h6);
      apb(1'b1, dadc_pkg::DADC_OFS_CTRL, 32'h0);
      chk(ref_out, 1'b0);
   endtask : t_ref

   task automatic t_rate();
      apb(1'b0, dadc_pkg::DADC_OFS_COUNT, 0);
      rd2 = rd;
      apb(1'b0, dadc_pkg::DADC_OFS_COUNT, 0);
      chk(rd - rd2, 32'h4);
      // divide by three keeps the tick below the rated clock
      apb(1'b1, dadc_pkg::DADC_OFS_DIV, 32'h2);
      apb(1'b0, dadc_pkg::DADC_OFS_DIV, 0);
      chk(rd, 32'h2);
      n = 0;
      repeat (30)
      begin
         @(negedge clock_in);
         n = n + int'(strobe);
      end
      chk(n, 10);
      @(posedge clock_in);
      apb(1'b1, dadc_pkg::DADC_OFS_DIV, 32'h0);
   endtask : t_rate

   initial
   begin
      rstn_in    = 1'b0;
      psel_in    = 1'b0;
      penable_in = 1'b0;
      pwrite_in  = 1'b0;
      paddr_in   = 8'h00;
      pwdata_in  = 32'h0;
      repeat (3) @(posedge clock_in);
      rstn_in <= 1'b1;
      @(posedge clock_in);
      t_reset();
      t_stream(1'b0);
      t_stream(1'b1);
      t_oe();
      t_pd();
      t_stream(1'b0);
      t_ref();
      t_rate();
      t_stream(1'b1);
      results();
   end
endmodule : testbench
